//--- logic/ixd_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "ixd_params.svh"
module ixd_exec #(
   parameter int DADDR_W = 12,
   parameter int PADDR_W = 16
) (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   // Instruction issue
   input  wire logic                start,
   input  wire ixd_pkg::ixd_op_t    op,
   input  wire logic [DADDR_W-1:0]  daddr,
   input  wire logic [2:0]          bit_sel,
   input  wire logic [7:0]          imm,
   input  wire logic                to_acc,
   // Data memory
   output logic                     dmem_rd_q,
   output logic                     dmem_wr_q,
   output logic [DADDR_W-1:0]       dmem_addr_q,
   output logic [7:0]               dmem_wdata_q,
   input  wire logic [7:0]          dmem_rdata,
   // Program memory
   output logic                     pmem_rd_q,
   output logic [PADDR_W-1:0]       pmem_addr_q,
   input  wire logic [15:0]         pmem_rdata,
   // Table pointers, writable by the core
   input  wire logic                tbl_lo_wr,
   input  wire logic                tbl_hi_wr,
   input  wire logic [7:0]          tbl_wdata,
   // Core state
   output logic [7:0]               acc_q,
   output logic [5:0]               flags_q,
   output logic [7:0]               table_pointer_low_q,
   output logic [7:0]               table_pointer_high_q,
   output logic [7:0]               table_high_byte_latch_q,
   output logic                     busy_q,
   output logic                     done_q,
   output logic                     skip_q
);
   import ixd_pkg::*;

   ixd_state_t    state_q;
   ixd_op_t       op_q;
   logic          to_acc_q;
   logic [2:0]    bit_q;
   logic [7:0]    imm_q;
   logic [7:0]    opnd;
   ixd_alu_res_t  alu;
   logic          is_skip;
   logic          skip_take;
   logic          is_table;
   logic          acc_dest;
   logic          z_only;
   logic          arith;

   function automatic logic op_is_table(ixd_op_t o);
      return (o == IXD_OP_TABLE_READ_FULL_POINTER) || (o == IXD_OP_TABLE_READ_LAST_PAGE) ||
             (o == IXD_OP_PRE_INC_TABLE_READ) || (o == IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE);
   endfunction : op_is_table

   function automatic logic op_is_last_page(ixd_op_t o);
      return (o == IXD_OP_TABLE_READ_LAST_PAGE) || (o == IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE);
   endfunction : op_is_last_page

   function automatic logic op_is_pre_inc(ixd_op_t o);
      return (o == IXD_OP_PRE_INC_TABLE_READ) || (o == IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE);
   endfunction : op_is_pre_inc

   assign opnd = (op_q == IXD_OP_XOR_IMM) ? imm_q : dmem_rdata;

   ixd_alu u_alu (
      .op      (op_q),
      .acc     (acc_q),
      .opnd    (opnd),
      .bit_sel (bit_q),
      .c_in    (flags_q[`IXD_FLG_C]),
      .ac_in   (flags_q[`IXD_FLG_AC]),
      .result  (alu)
   );

   always_comb begin
      is_skip  = (op_q == IXD_OP_SKIP_ZERO_MOVE_TO_ACC) || (op_q == IXD_OP_SKIP_WHEN_ZERO_BIT);
      skip_take = (op_q == IXD_OP_SKIP_ZERO_MOVE_TO_ACC) ? (dmem_rdata == 8'h00) :
                  (op_q == IXD_OP_SKIP_WHEN_ZERO_BIT) ? !dmem_rdata[bit_q] : 1'b0;
      is_table = op_is_table(op_q);
      acc_dest = (op_q == IXD_OP_MOVE_TO_ACC) || (op_q == IXD_OP_SKIP_ZERO_MOVE_TO_ACC) ||
                 (op_q == IXD_OP_XOR_IMM) ||
                 (to_acc_q && ((op_q == IXD_OP_XOR) || (op_q == IXD_OP_ADD) ||
                  (op_q == IXD_OP_ADD_WITH_CARRY) || (op_q == IXD_OP_AND) ||
                  (op_q == IXD_OP_OR) || (op_q == IXD_OP_INVERT) ||
                  (op_q == IXD_OP_DECREMENT) || (op_q == IXD_OP_INCREMENT)));
      z_only   = (op_q == IXD_OP_XOR) || (op_q == IXD_OP_XOR_IMM) || (op_q == IXD_OP_AND) ||
                 (op_q == IXD_OP_OR) || (op_q == IXD_OP_INVERT) ||
                 (op_q == IXD_OP_DECREMENT) || (op_q == IXD_OP_INCREMENT);
      arith    = (op_q == IXD_OP_ADD) || (op_q == IXD_OP_ADD_WITH_CARRY);
   end

   // Sequencer
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_q  <= IXD_ST_IDLE;
         op_q     <= IXD_OP_NONE;
         to_acc_q <= 1'b0;
         bit_q    <= 3'h0;
         imm_q    <= 8'h00;
      end else begin
         case (state_q)
            IXD_ST_IDLE: begin
               if (start) begin
                  op_q     <= op;
                  to_acc_q <= to_acc;
                  bit_q    <= bit_sel;
                  imm_q    <= imm;
                  state_q  <= op_is_table(op) ? IXD_ST_FETCH : IXD_ST_WRITE;
               end
            end
            IXD_ST_FETCH: state_q <= IXD_ST_WRITE;
            IXD_ST_WRITE: begin
               state_q <= (is_skip && skip_take) ? IXD_ST_DUMMY : IXD_ST_IDLE;
            end
            IXD_ST_DUMMY: state_q <= IXD_ST_IDLE;
            default: state_q <= IXD_ST_IDLE;
         endcase
      end
   end

   // Memory strobes
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         dmem_rd_q    <= 1'b0;
         dmem_wr_q    <= 1'b0;
         dmem_addr_q  <= '0;
         dmem_wdata_q <= 8'h00;
         pmem_rd_q    <= 1'b0;
         pmem_addr_q  <= '0;
      end else begin
         dmem_rd_q <= 1'b0;
         dmem_wr_q <= 1'b0;
         pmem_rd_q <= 1'b0;
         if ((state_q == IXD_ST_IDLE) && start) begin
            // Full data address in every long form
            dmem_addr_q <= daddr;
            dmem_rd_q   <= !op_is_table(op) && (op != IXD_OP_XOR_IMM);
            if (op_is_table(op)) begin
               pmem_rd_q <= 1'b1;
               pmem_addr_q <= PADDR_W'({op_is_last_page(op) ? `IXD_LAST_PAGE :
                                        (tbl_hi_wr ? tbl_wdata : table_pointer_high_q),
                                        op_is_pre_inc(op) ? table_pointer_low_q + 8'h01 :
                                        (tbl_lo_wr ? tbl_wdata : table_pointer_low_q)});
            end
         end
         if (state_q == IXD_ST_WRITE && !acc_dest && !is_skip &&
             (op_q != IXD_OP_NONE)) begin
            dmem_wr_q    <= 1'b1;
            dmem_wdata_q <= is_table ? pmem_rdata[7:0] : alu.res;
         end
      end
   end

   // Accumulator and flags
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         acc_q   <= `IXD_RST_ACC;
         flags_q <= `IXD_RST_FLAGS;
      end else if (state_q == IXD_ST_WRITE) begin
         if (op_q == IXD_OP_SKIP_ZERO_MOVE_TO_ACC || op_q == IXD_OP_MOVE_TO_ACC) begin
            acc_q <= dmem_rdata;
         end else if (acc_dest) begin
            acc_q <= alu.res;
         end
         if (z_only || arith) begin
            flags_q[`IXD_FLG_Z] <= (alu.res == 8'h00);
         end
         if (arith) begin
            flags_q[`IXD_FLG_C]  <= alu.c;
            flags_q[`IXD_FLG_AC] <= alu.ac;
            flags_q[`IXD_FLG_OV] <= alu.ov;
            flags_q[`IXD_FLG_SC] <= alu.sc;
         end
         if (op_q == IXD_OP_BCD_ADJUST) begin
            flags_q[`IXD_FLG_C] <= alu.c;
         end
      end
   end

   // Table pointers and latch
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         table_pointer_low_q     <= `IXD_RST_TBL;
         table_pointer_high_q    <= `IXD_RST_TBL;
         table_high_byte_latch_q <= `IXD_RST_TBL;
      end else begin
         if (tbl_hi_wr) begin
            table_pointer_high_q <= tbl_wdata;
         end
         if ((state_q == IXD_ST_IDLE) && start && op_is_pre_inc(op)) begin
            table_pointer_low_q <= table_pointer_low_q + 8'h01;
         end else if (tbl_lo_wr) begin
            table_pointer_low_q <= tbl_wdata;
         end
         if (state_q == IXD_ST_WRITE && is_table) begin
            table_high_byte_latch_q <= pmem_rdata[15:8];
         end
      end
   end

   // Status outputs
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         skip_q <= 1'b0;
      end else begin
         busy_q <= ((state_q == IXD_ST_IDLE) && start) ||
                   (state_q == IXD_ST_FETCH) ||
                   ((state_q == IXD_ST_WRITE) && is_skip && skip_take);
         done_q <= (state_q == IXD_ST_WRITE) && !(is_skip && skip_take) ||
                   (state_q == IXD_ST_DUMMY);
         skip_q <= (state_q == IXD_ST_WRITE) && is_skip && skip_take;
      end
   end

   a_skip_flags: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && is_skip) |=> $stable(flags_q))
      else $error("skip changed flags");

   // Taken skip lasts one extra cycle
   sequence s_skip_taken;
      state_q == IXD_ST_WRITE && is_skip && skip_take;
   endsequence
   a_skip_dummy: assert property (@(posedge mclk) disable iff (!rst_b)
      s_skip_taken |=> skip_q && state_q == IXD_ST_DUMMY ##1 done_q)
      else $error("skip dummy cycle wrong");

   a_table_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && is_table) |=>
      table_high_byte_latch_q == $past(pmem_rdata[15:8]) && dmem_wr_q)
      else $error("table latch wrong");

   a_last_page: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_IDLE && start && op_is_last_page(op)) |=>
      pmem_addr_q[15:8] == `IXD_LAST_PAGE)
      else $error("last page address wrong");

   a_pre_inc: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_IDLE && start && op_is_pre_inc(op)) |=>
      pmem_addr_q[7:0] == table_pointer_low_q)
      else $error("pre increment read wrong");

   a_acc_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && acc_dest) |=> !dmem_wr_q)
      else $error("memory written for acc result");

   a_zero_flag: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && z_only) |=> flags_q[`IXD_FLG_Z] == $past(alu.res == 8'h00)
      && flags_q[`IXD_FLG_C] == $past(flags_q[`IXD_FLG_C]))
      else $error("zero flag wrong");

   a_move_flags: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && (op_q == IXD_OP_MOVE_TO_ACC || op_q == IXD_OP_MOVE_TO_MEM))
      |=> $stable(flags_q))
      else $error("move changed flags");

   a_skip_load: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_SKIP_ZERO_MOVE_TO_ACC) |=>
      acc_q == $past(dmem_rdata) && skip_q == ($past(dmem_rdata) == 8'h00))
      else $error("skip move result wrong");

   a_bit_skip: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_SKIP_WHEN_ZERO_BIT) |=>
      skip_q == !$past(dmem_rdata[bit_q]))
      else $error("bit skip wrong");

   a_table_full: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_IDLE && start && op == IXD_OP_TABLE_READ_FULL_POINTER &&
       !tbl_lo_wr && !tbl_hi_wr) |=> pmem_rd_q &&
      pmem_addr_q == PADDR_W'({$past(table_pointer_high_q), $past(table_pointer_low_q)}))
      else $error("full pointer address wrong");

   a_full_addr: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_IDLE && start) |=> dmem_addr_q == $past(daddr))
      else $error("data address wrong");

   a_add_sum: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_ADD && to_acc_q) |=>
      {flags_q[`IXD_FLG_C], acc_q} == $past({1'b0, acc_q} + {1'b0, dmem_rdata}))
      else $error("add result wrong");

   a_adc_sum: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_ADD_WITH_CARRY && to_acc_q) |=>
      {flags_q[`IXD_FLG_C], acc_q} ==
      $past({1'b0, acc_q} + {1'b0, dmem_rdata} + {8'h00, flags_q[`IXD_FLG_C]}))
      else $error("add with carry result wrong");

   a_logic_flags: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && z_only) |=>
      {flags_q[5:3], flags_q[1:0]} == $past({flags_q[5:3], flags_q[1:0]}))
      else $error("logic op changed flags");

   a_clear_byte: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_CLEAR) |=>
      dmem_wr_q && dmem_wdata_q == 8'h00 && $stable(flags_q))
      else $error("clear wrong");

   a_bit_clear: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_CLEAR_BIT) |=>
      dmem_wr_q && !dmem_wdata_q[bit_q] && $stable(flags_q) &&
      (dmem_wdata_q | (8'h01 << bit_q)) == ($past(dmem_rdata) | (8'h01 << bit_q)))
      else $error("bit clear wrong");

   a_bcd_flags: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_BCD_ADJUST) |=>
      dmem_wr_q && flags_q[5:1] == $past(flags_q[5:1]))
      else $error("adjust changed flags");

   a_inc_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_INCREMENT) |=>
      flags_q[`IXD_FLG_Z] == ($past(dmem_rdata) == 8'hff))
      else $error("increment zero flag wrong");

   // Rotate feeds bit 7 to bit 0
   a_rotate: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == IXD_ST_WRITE && op_q == IXD_OP_ROTATE_LEFT) |=>
      dmem_wr_q && $stable(flags_q) &&
      dmem_wdata_q == {$past(dmem_rdata[6:0]), $past(dmem_rdata[7])})
      else $error("rotate wrong");
endmodule : ixd_exec
`default_nettype wire

//--- logic/ixd_params.svh
`ifndef IXD_PARAMS_SVH
`define IXD_PARAMS_SVH
`define IXD_RST_ACC        8'h00
`define IXD_RST_FLAGS      6'h00
`define IXD_RST_TBL        8'h00
`define IXD_BCD_LIMIT      4'h9
`define IXD_BCD_STEP       4'h6
`define IXD_LAST_PAGE      8'hff
`define IXD_FLG_C          0
`define IXD_FLG_AC         1
`define IXD_FLG_Z          2
`define IXD_FLG_OV         3
`define IXD_FLG_SC         4
`define IXD_FLG_CZ         5
`endif

//--- logic/ixd_pkg.sv
package ixd_pkg;
   typedef enum logic [4:0] {
      IXD_OP_NONE,
      IXD_OP_SKIP_ZERO_MOVE_TO_ACC,
      IXD_OP_SKIP_WHEN_ZERO_BIT,
      IXD_OP_TABLE_READ_FULL_POINTER,
      IXD_OP_TABLE_READ_LAST_PAGE,
      IXD_OP_PRE_INC_TABLE_READ,
      IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE,
      IXD_OP_XOR,
      IXD_OP_XOR_IMM,
      IXD_OP_ADD_WITH_CARRY,
      IXD_OP_ADD,
      IXD_OP_AND,
      IXD_OP_OR,
      IXD_OP_CLEAR,
      IXD_OP_CLEAR_BIT,
      IXD_OP_INVERT,
      IXD_OP_BCD_ADJUST,
      IXD_OP_DECREMENT,
      IXD_OP_INCREMENT,
      IXD_OP_MOVE_TO_ACC,
      IXD_OP_MOVE_TO_MEM,
      IXD_OP_ROTATE_LEFT
   } ixd_op_t;

   typedef enum logic [1:0] {
      IXD_ST_IDLE,
      IXD_ST_FETCH,
      IXD_ST_WRITE,
      IXD_ST_DUMMY
   } ixd_state_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       ac;
      logic       ov;
      logic       sc;
   } ixd_alu_res_t;
endpackage : ixd_pkg

//--- logic/ixd_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "ixd_params.svh"
module ixd_alu (
   // Operands
   input  wire ixd_pkg::ixd_op_t op,
   input  wire logic [7:0]       acc,
   input  wire logic [7:0]       opnd,
   input  wire logic [2:0]       bit_sel,
   input  wire logic             c_in,
   input  wire logic             ac_in,
   // Result
   output var ixd_pkg::ixd_alu_res_t result
);
   import ixd_pkg::*;

   logic [8:0] sum;
   logic [4:0] lo_sum;
   logic [7:0] sum7;
   logic       add_c;
   logic [8:0] bcd;

   always_comb begin
      add_c  = (op == IXD_OP_ADD_WITH_CARRY) ? c_in : 1'b0;
      sum    = {1'b0, acc} + {1'b0, opnd} + {8'h00, add_c};
      lo_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, add_c};
      sum7   = {1'b0, acc[6:0]} + {1'b0, opnd[6:0]} + {7'h00, add_c};
      bcd    = {1'b0, acc};
      if ((acc[3:0] > `IXD_BCD_LIMIT) || ac_in) begin
         bcd = bcd + {5'h00, `IXD_BCD_STEP};
      end
      if ((bcd[7:4] > `IXD_BCD_LIMIT) || c_in || bcd[8]) begin
         bcd = bcd + {1'b0, `IXD_BCD_STEP, 4'h0};
      end
      result.res = opnd;
      result.c   = c_in;
      result.ac  = ac_in;
      result.ov  = 1'b0;
      result.sc  = 1'b0;
      case (op)
         IXD_OP_ADD_WITH_CARRY, IXD_OP_ADD: begin
            result.res = sum[7:0];
            result.c   = sum[8];
            result.ac  = lo_sum[4];
            result.ov  = sum[8] ^ sum7[7];
            result.sc  = sum[8] ^ sum7[7] ^ sum[7];
         end
         IXD_OP_XOR, IXD_OP_XOR_IMM: result.res = acc ^ opnd;
         IXD_OP_AND:          result.res = acc & opnd;
         IXD_OP_OR:           result.res = acc | opnd;
         IXD_OP_CLEAR:        result.res = 8'h00;
         IXD_OP_CLEAR_BIT:    result.res = opnd & ~(8'h01 << bit_sel);
         IXD_OP_INVERT:       result.res = ~opnd;
         IXD_OP_BCD_ADJUST: begin
            result.res = bcd[7:0];
            result.c   = c_in | bcd[8];
         end
         IXD_OP_DECREMENT:    result.res = opnd - 8'h01;
         IXD_OP_INCREMENT:    result.res = opnd + 8'h01;
         IXD_OP_MOVE_TO_MEM:  result.res = acc;
         IXD_OP_ROTATE_LEFT:  result.res = {opnd[6:0], opnd[7]};
         default:             result.res = opnd;
      endcase
   end
endmodule : ixd_alu
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ixd_params.svh"
module tb_top;
   import ixd_pkg::*;
   logic        mclk, rst_b, start, to_acc, tbl_lo_wr, tbl_hi_wr;
   ixd_op_t     op;
   logic [11:0] daddr, dmem_addr_q;
   logic [2:0]  bit_sel;
   logic [7:0]  imm, tbl_wdata, dmem_rdata, dmem_wdata_q, acc_q, tlo_q, thi_q, lat_q;
   logic [15:0] pmem_rdata, pmem_addr_q;
   logic        dmem_rd_q, dmem_wr_q, pmem_rd_q, busy_q, done_q, skip_q;
   logic [5:0]  flags_q, e_flg;
   logic [7:0]  mem [0:4095];
   logic [7:0]  e_acc, e_tlo, e_thi, e_lat;
   int          mismatches = 0;
   int          comparisons = 0;

   ixd_exec DUT (.mclk(mclk), .rst_b(rst_b), .start(start), .op(op), .daddr(daddr),
      .bit_sel(bit_sel), .imm(imm), .to_acc(to_acc), .dmem_rd_q(dmem_rd_q),
      .dmem_wr_q(dmem_wr_q), .dmem_addr_q(dmem_addr_q), .dmem_wdata_q(dmem_wdata_q),
      .dmem_rdata(dmem_rdata), .pmem_rd_q(pmem_rd_q), .pmem_addr_q(pmem_addr_q),
      .pmem_rdata(pmem_rdata), .tbl_lo_wr(tbl_lo_wr), .tbl_hi_wr(tbl_hi_wr),
      .tbl_wdata(tbl_wdata), .acc_q(acc_q), .flags_q(flags_q),
      .table_pointer_low_q(tlo_q), .table_pointer_high_q(thi_q),
      .table_high_byte_latch_q(lat_q), .busy_q(busy_q), .done_q(done_q), .skip_q(skip_q));

   function automatic logic [15:0] pword(input logic [15:0] a);
      return {a[7:0] ^ 8'h3c, a[15:8] ^ 8'ha5};
   endfunction : pword

   // Memories answer from the held address
   assign dmem_rdata = mem[dmem_addr_q];
   assign pmem_rdata = pword(pmem_addr_q);
   always @(posedge mclk) begin
      if (dmem_wr_q) mem[dmem_addr_q] <= dmem_wdata_q;
   end

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check

   task automatic set_tbl(input logic [7:0] lo, input logic [7:0] hi);
      tbl_wdata = lo;
      tbl_lo_wr = 1'b1;
      @(posedge mclk);
      #1;
      tbl_lo_wr = 1'b0;
      tbl_hi_wr = 1'b1;
      tbl_wdata = hi;
      @(posedge mclk);
      #1;
      tbl_hi_wr = 1'b0;
      e_tlo = lo;
      e_thi = hi;
      check(tlo_q, lo);
      check(thi_q, hi);
   endtask : set_tbl

   // Issue one instruction, wait for done, compare against the reference
   task automatic run_op(input ixd_op_t o, input logic ta, input logic [11:0] ad,
                         input logic [2:0] bs, input logic [7:0] im, input logic hold);
      logic [7:0]  a, d, r, na, s7;
      logic [8:0]  s;
      logic [4:0]  s4;
      logic [15:0] pa, w;
      logic        ci, wm, sk, zo, hi, lo6, seen, wr, tr;
      logic [3:0]  n, ec;
      a = e_acc;
      d = mem[ad];
      r = d;
      na = a;
      pa = 16'h0000;
      {wm, sk, seen, wr, tr} = 5'h00;
      n = 4'h0;
      ec = 4'h1;
      case (o)
         IXD_OP_SKIP_ZERO_MOVE_TO_ACC: begin
            na = d;
            sk = (d == 8'h00);
         end
         IXD_OP_SKIP_WHEN_ZERO_BIT: sk = !d[bs];
         IXD_OP_TABLE_READ_FULL_POINTER, IXD_OP_TABLE_READ_LAST_PAGE,
         IXD_OP_PRE_INC_TABLE_READ, IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE: begin
            if (o == IXD_OP_PRE_INC_TABLE_READ || o == IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE)
               e_tlo = e_tlo + 8'h01;
            hi = (o == IXD_OP_TABLE_READ_LAST_PAGE || o == IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE);
            pa = {hi ? `IXD_LAST_PAGE : e_thi, e_tlo};
            w = pword(pa);
            r = w[7:0];
            e_lat = w[15:8];
            {wm, tr} = 2'h3;
            ec = 4'h2;
         end
         IXD_OP_XOR:         r = a ^ d;
         IXD_OP_XOR_IMM:     r = a ^ im;
         IXD_OP_AND:         r = a & d;
         IXD_OP_OR:          r = a | d;
         IXD_OP_CLEAR:       r = 8'h00;
         IXD_OP_CLEAR_BIT:   r = d & ~(8'h01 << bs);
         IXD_OP_INVERT:      r = ~d;
         IXD_OP_DECREMENT:   r = d - 8'h01;
         IXD_OP_INCREMENT:   r = d + 8'h01;
         IXD_OP_MOVE_TO_ACC: na = d;
         IXD_OP_MOVE_TO_MEM: r = a;
         IXD_OP_ROTATE_LEFT: r = {d[6:0], d[7]};
         IXD_OP_BCD_ADJUST: begin
            lo6 = (a[3:0] > `IXD_BCD_LIMIT) | e_flg[`IXD_FLG_AC];
            s = {1'b0, a} + {5'h00, lo6 ? `IXD_BCD_STEP : 4'h0};
            hi = (s[7:4] > `IXD_BCD_LIMIT) | e_flg[`IXD_FLG_C] | s[8];
            r = s[7:0] + {hi ? `IXD_BCD_STEP : 4'h0, 4'h0};
            e_flg[`IXD_FLG_C] = hi;
         end
         IXD_OP_ADD, IXD_OP_ADD_WITH_CARRY: begin
            ci = (o == IXD_OP_ADD_WITH_CARRY) & e_flg[`IXD_FLG_C];
            s = {1'b0, a} + {1'b0, d} + {8'h00, ci};
            s7 = {1'b0, a[6:0]} + {1'b0, d[6:0]} + {7'h00, ci};
            s4 = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, ci};
            r = s[7:0];
            e_flg[`IXD_FLG_C] = s[8];
            e_flg[`IXD_FLG_AC] = s4[4];
            e_flg[`IXD_FLG_OV] = s[8] ^ s7[7];
            e_flg[`IXD_FLG_SC] = s[8] ^ s7[7] ^ r[7];
         end
         default: ;
      endcase
      if (o inside {IXD_OP_CLEAR, IXD_OP_CLEAR_BIT, IXD_OP_BCD_ADJUST, IXD_OP_MOVE_TO_MEM,
                    IXD_OP_ROTATE_LEFT})
         wm = 1'b1;
      zo = o inside {IXD_OP_XOR, IXD_OP_XOR_IMM, IXD_OP_AND, IXD_OP_OR, IXD_OP_INVERT,
                     IXD_OP_DECREMENT, IXD_OP_INCREMENT, IXD_OP_ADD, IXD_OP_ADD_WITH_CARRY};
      if (zo) begin
         e_flg[`IXD_FLG_Z] = (r == 8'h00);
         if (ta || o == IXD_OP_XOR_IMM)
            na = r;
         else
            wm = 1'b1;
      end
      if (sk) ec = 4'h2;
      e_acc = na;
      op = o;
      daddr = ad;
      bit_sel = bs;
      imm = im;
      to_acc = ta;
      start = 1'b1;
      @(posedge mclk);
      #1;
      start = hold;
      check({busy_q, pmem_rd_q, dmem_rd_q}, {1'b1, tr, !tr && o != IXD_OP_XOR_IMM});
      do begin
         @(posedge mclk);
         #1;
         start = 1'b0;
         n = n + 4'h1;
         seen = seen | (skip_q === 1'b1);
         wr = wr | (dmem_wr_q === 1'b1);
      end while (done_q !== 1'b1 && n < 4'ha);
      check(n, ec);
      check(seen, sk);
      check(wr, wm);
      check(dmem_addr_q, ad);
      if (wm) check(dmem_wdata_q, r);
      check(acc_q, e_acc);
      check(flags_q, e_flg);
      check(lat_q, e_lat);
      check(tlo_q, e_tlo);
      if (tr) check(pmem_addr_q, pa);
      // Idle edge keeps the memory write and start apart from the next issue
      @(posedge mclk);
      #1;
      check({busy_q, done_q, skip_q}, 3'h0);
   endtask : run_op

   task automatic t_arith();
      mem[12'h400] = 8'h7f;
      mem[12'h401] = 8'h01;
      mem[12'h402] = 8'hff;
      mem[12'h403] = 8'h49;
      mem[12'h404] = 8'h38;
      mem[12'h405] = 8'h95;
      mem[12'h406] = 8'h27;
      run_op(IXD_OP_MOVE_TO_ACC, 1'b0, 12'h400, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD, 1'b1, 12'h401, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD, 1'b1, 12'h402, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD_WITH_CARRY, 1'b0, 12'h401, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD_WITH_CARRY, 1'b1, 12'h402, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD, 1'b0, 12'h402, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_MOVE_TO_ACC, 1'b0, 12'h404, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD, 1'b1, 12'h403, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_BCD_ADJUST, 1'b0, 12'h407, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_MOVE_TO_ACC, 1'b0, 12'h405, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_ADD, 1'b1, 12'h406, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_BCD_ADJUST, 1'b0, 12'h408, 3'h0, 8'h00, 1'b0);
   endtask : t_arith

   task automatic t_skip();
      mem[12'h010] = 8'h00;
      mem[12'h011] = 8'h80;
      mem[12'h012] = 8'hf7;
      run_op(IXD_OP_SKIP_ZERO_MOVE_TO_ACC, 1'b0, 12'h010, 3'h0, 8'h00, 1'b1);
      run_op(IXD_OP_SKIP_ZERO_MOVE_TO_ACC, 1'b0, 12'h011, 3'h0, 8'h00, 1'b0);
      for (int i = 0; i < 8; i++)
         run_op(IXD_OP_SKIP_WHEN_ZERO_BIT, 1'b0, 12'h012, 3'(i), 8'h00, 1'b0);
   endtask : t_skip

   task automatic t_move_table();
      mem[12'hf34] = 8'h5a;
      run_op(IXD_OP_MOVE_TO_ACC, 1'b0, 12'hf34, 3'h0, 8'h00, 1'b1);
      run_op(IXD_OP_MOVE_TO_MEM, 1'b0, 12'h823, 3'h0, 8'h00, 1'b0);
      set_tbl(8'h12, 8'h34);
      run_op(IXD_OP_TABLE_READ_FULL_POINTER, 1'b0, 12'h500, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_TABLE_READ_LAST_PAGE, 1'b0, 12'h600, 3'h0, 8'h00, 1'b0);
      set_tbl(8'hff, 8'h34);
      run_op(IXD_OP_PRE_INC_TABLE_READ, 1'b0, 12'h700, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_PRE_INC_TABLE_READ_LAST_PAGE, 1'b0, 12'he00, 3'h0, 8'h00, 1'b0);
   endtask : t_move_table

   task automatic t_logic();
      ixd_op_t zl [7];
      zl = '{IXD_OP_XOR, IXD_OP_AND, IXD_OP_OR, IXD_OP_INVERT, IXD_OP_DECREMENT,
             IXD_OP_INCREMENT, IXD_OP_XOR};
      mem[12'h300] = 8'h5a;
      mem[12'h301] = 8'h01;
      mem[12'h302] = 8'hff;
      mem[12'h303] = 8'h81;
      for (int i = 0; i < 7; i++)
         for (int j = 0; j < 4; j++)
            run_op(zl[i], j[0], 12'h300 + 12'(j), 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_XOR_IMM, 1'b1, 12'h300, 3'h0, 8'h3c, 1'b0);
      run_op(IXD_OP_XOR_IMM, 1'b1, 12'h300, 3'h0, e_acc, 1'b0);
      run_op(IXD_OP_CLEAR_BIT, 1'b0, 12'h302, 3'h7, 8'h00, 1'b0);
      run_op(IXD_OP_ROTATE_LEFT, 1'b0, 12'h303, 3'h0, 8'h00, 1'b0);
      run_op(IXD_OP_CLEAR, 1'b0, 12'h303, 3'h0, 8'h00, 1'b0);
   endtask : t_logic

   // Roughly 2000 cycles, far beyond the expected run
   initial begin
      #10000;
      mismatches++;
      summarize();
   end

   initial begin
      {start, to_acc, tbl_lo_wr, tbl_hi_wr, rst_b} = 5'h00;
      op = IXD_OP_NONE;
      daddr = 12'h000;
      bit_sel = 3'h0;
      imm = 8'h00;
      tbl_wdata = 8'h00;
      {e_acc, e_tlo, e_thi, e_lat} = 32'h0;
      e_flg = 6'h00;
      repeat (3) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      check({busy_q, done_q, skip_q, flags_q}, 16'h0000);
      check({acc_q, tlo_q}, 16'h0000);
      check({thi_q, lat_q}, 16'h0000);
      t_arith();
      t_skip();
      t_move_table();
      t_logic();
      summarize();
   end
endmodule : tb_top
`default_nettype wire
